/* File: logic/reset_cause_and_init_control.sv */
// Reset cause classification, register initialisation strobe and wake-up control.
// Assumes all inputs synchronous to i_ref_clk; i_rst is the power-on reset.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module reset_cause_and_init_control
#(
  parameter int unsigned CAL_W = 8,
  parameter logic [CAL_W-1:0] CAL_DEFAULT = 8'h80
)
(
  // Clock and power-on reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Reset sources and core state
  input wire logic i_master_clear_n,
  input wire logic i_brownout,
  input wire logic i_wdt_timeout,
  input wire logic i_sleeping,
  // Wake events
  input wire logic i_wake_irq,
  input wire logic i_wake_in_core,
  input wire logic [2:0] i_wake_bit,
  input wire logic [7:0] i_next_pc,
  // Programming port
  input wire logic i_prog_wr,
  input wire logic [13:0] i_prog_addr,
  input wire logic [CAL_W-1:0] i_prog_data,
  input wire logic i_bulk_erase,
  // Control outputs
  output logic o_reg_reset,
  output logic o_wake,
  output logic o_pc_load,
  output logic [7:0] o_pc_value,
  output logic o_global_irq_enable,
  output logic [CAL_W-1:0] o_osc_trim,
  output reset_ctl_pkg::cause_t o_cause
);
  import reset_ctl_pkg::*;

  localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(MASTER_CLEAR_FILT_CYC);

  state_t state_q;
  logic [FILT_W-1:0] master_clear_cnt_q;
  logic master_clear_act;
  logic rst_src;
  logic rst_entry;
  logic wdt_wake;
  logic irq_wake;
  logic [7:0] wake_mask;
  logic [7:0] status_q;
  logic [7:0] power_control_flags_q;
  logic [7:0] irq_ctrl_q;
  logic [7:0] periph_q;
  logic [7:0] keep_q;
  logic [7:0] rdata_q;
  logic [CAL_W-1:0] cal_q;
  logic reg_reset_q;
  logic wake_q;
  logic pc_load_q;
  logic [7:0] pc_q;
  cause_t cause_q;
  cause_t cause_d;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      master_clear_cnt_q <= '0;
    else if (i_master_clear_n)
      master_clear_cnt_q <= '0;
    else if (master_clear_cnt_q != FILT_MAX)
      master_clear_cnt_q <= master_clear_cnt_q + 1'b1;
  end

  assign master_clear_act = (master_clear_cnt_q == FILT_MAX);
  // A watchdog timeout only resets while the core runs
  assign rst_src = master_clear_act | i_brownout | (i_wdt_timeout & ~i_sleeping);
  assign rst_entry = rst_src & (state_q == ST_RUN);
  assign wdt_wake = i_wdt_timeout & i_sleeping & ~rst_src & (state_q == ST_RUN);
  assign irq_wake = i_wake_irq & i_sleeping & ~rst_src & (state_q == ST_RUN);
  assign wake_mask = 8'h01 << i_wake_bit;

  always_comb
  begin
    if (i_brownout)
      cause_d = CAUSE_BOR;
    else if (master_clear_act)
      cause_d = i_sleeping ? CAUSE_MASTER_CLEAR_SLEEP : CAUSE_MASTER_CLEAR_RUN;
    else
      cause_d = CAUSE_WDT_RUN;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      state_q <= ST_RUN;
    else
    begin
      unique case (state_q)
        ST_RUN:
          if (rst_src)
            state_q <= ST_HOLD;
        ST_HOLD:
          if (!rst_src)
            state_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      cause_q <= CAUSE_POR;
    else if (rst_entry)
      cause_q <= cause_d;
    else if (wdt_wake)
      cause_q <= CAUSE_WDT_SLEEP;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      reg_reset_q <= 1'b1;
    else
      reg_reset_q <= rst_src;
  end

  // timeout and power-down flags per cause
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      status_q <= STATUS_POR_VAL;
    else if (rst_entry)
    begin
      status_q[7:5] <= 3'h0;
      unique case (cause_d)
        CAUSE_WDT_RUN:
        begin
          status_q[STATUS_TO_BIT] <= 1'b0;
          status_q[STATUS_PD_BIT] <= 1'b1;
        end
        CAUSE_MASTER_CLEAR_SLEEP:
        begin
          status_q[STATUS_TO_BIT] <= 1'b1;
          status_q[STATUS_PD_BIT] <= 1'b0;
        end
        CAUSE_BOR:
        begin
          status_q[STATUS_TO_BIT] <= 1'b1;
          status_q[STATUS_PD_BIT] <= 1'b1;
        end
        default:
        begin
          status_q[STATUS_TO_BIT] <= status_q[STATUS_TO_BIT];
          status_q[STATUS_PD_BIT] <= status_q[STATUS_PD_BIT];
        end
      endcase
    end
    else if (wdt_wake | irq_wake)
    begin
      status_q[STATUS_TO_BIT] <= ~wdt_wake;
      status_q[STATUS_PD_BIT] <= 1'b0;
    end
    else if (i_wr && i_addr == ADDR_STATUS)
    begin
      // Timeout and power-down flags are read-only to software
      status_q[7:5] <= i_wdata[7:5];
      status_q[2:0] <= i_wdata[2:0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      power_control_flags_q <= POWER_CONTROL_FLAGS_POR_VAL;
    else if (rst_entry && cause_d == CAUSE_BOR)
      power_control_flags_q[POWER_CONTROL_FLAGS_BOR_BIT] <= 1'b0;
    else if (i_wr && i_addr == ADDR_POWER_CONTROL_FLAGS)
      power_control_flags_q <= i_wdata & POWER_CONTROL_FLAGS_MASK;
  end

  // core interrupt control loads reset state
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      irq_ctrl_q <= REG_RST_VAL;
    else if (rst_src)
      irq_ctrl_q <= REG_RST_VAL;
    else
    begin
      // wake source flag, set wins over a write
      irq_ctrl_q <= ((i_wr && i_addr == ADDR_IRQ_CTRL) ? i_wdata : irq_ctrl_q)
        | ((irq_wake & i_wake_in_core) ? wake_mask : 8'h00);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      periph_q <= REG_RST_VAL;
    else if (rst_src)
      periph_q <= REG_RST_VAL;
    else
    begin
      periph_q <= (((i_wr && i_addr == ADDR_PERIPH_FLAGS) ? i_wdata : periph_q)
        | ((irq_wake & ~i_wake_in_core) ? wake_mask : 8'h00)) & PERIPH_MASK;
    end
  end

  // kept through all but power-on; its power-on content carries no meaning
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      keep_q <= REG_RST_VAL;
    else if (i_wr && i_addr == ADDR_KEEP)
      keep_q <= i_wdata;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      cal_q <= CAL_DEFAULT;
    else if (i_prog_wr && i_prog_addr == CAL_WORD_ADDR)
      cal_q <= i_prog_data;
  end

  // program counter on reset and wake
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pc_load_q <= 1'b1;
      pc_q <= REG_RST_VAL;
    end
    else if (rst_entry)
    begin
      pc_load_q <= 1'b1;
      pc_q <= REG_RST_VAL;
    end
    else if (irq_wake)
    begin
      pc_load_q <= 1'b1;
      pc_q <= irq_ctrl_q[GIE_BIT] ? PC_VECTOR : i_next_pc;
    end
    else if (wdt_wake)
    begin
      pc_load_q <= 1'b1;
      pc_q <= i_next_pc;
    end
    else if (i_wr && i_addr == ADDR_PCL)
    begin
      pc_load_q <= 1'b1;
      pc_q <= i_wdata;
    end
    else
      pc_load_q <= 1'b0;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      wake_q <= 1'b0;
    else
      wake_q <= wdt_wake | irq_wake;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_q <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        ADDR_PCL: rdata_q <= pc_q;
        ADDR_STATUS: rdata_q <= status_q;
        ADDR_IRQ_CTRL: rdata_q <= irq_ctrl_q;
        ADDR_PERIPH_FLAGS: rdata_q <= periph_q;
        ADDR_POWER_CONTROL_FLAGS: rdata_q <= power_control_flags_q;
        ADDR_KEEP: rdata_q <= keep_q;
        ADDR_CAUSE: rdata_q <= {2'h0, cause_q};
        ADDR_CAL: rdata_q <= 8'(cal_q);
        default: rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign o_rdata = rdata_q;
  assign o_reg_reset = reg_reset_q;
  assign o_wake = wake_q;
  assign o_pc_load = pc_load_q;
  assign o_pc_value = pc_q;
  assign o_global_irq_enable = irq_ctrl_q[GIE_BIT];
  assign o_osc_trim = cal_q;
  assign o_cause = cause_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  chk_cause_onehot: assert property ($onehot(o_cause))
    else $error("cause record not one-hot");

  chk_keep_through_reset: assert property (
    rst_src && !(i_wr && i_addr == ADDR_KEEP) |=> $stable(keep_q))
    else $error("unaffected register changed by reset");

  chk_reset_state_load: assert property (
    rst_src |=> o_reg_reset && irq_ctrl_q == REG_RST_VAL && periph_q == REG_RST_VAL)
    else $error("registers not in reset state during reset");

  chk_wdt_sleep_wake: assert property (
    wdt_wake |=> !o_reg_reset && o_wake && o_cause == CAUSE_WDT_SLEEP)
    else $error("watchdog in sleep did not wake cleanly");

  chk_wdt_run_flags: assert property (
    rst_entry && cause_d == CAUSE_WDT_RUN |=> !status_q[STATUS_TO_BIT] && status_q[STATUS_PD_BIT])
    else $error("wrong flags after running watchdog reset");

  chk_master_clear_glitch_filter: assert property (
    $fell(i_master_clear_n) |-> !master_clear_act [*3])
    else $error("master-clear acted on a short pulse");

  chk_cal_bulk_erase: assert property (
    i_bulk_erase && !(i_prog_wr && i_prog_addr == CAL_WORD_ADDR) |=> $stable(o_osc_trim))
    else $error("calibration word lost on bulk erase");

  chk_wake_vector_load: assert property (
    irq_wake && irq_ctrl_q[GIE_BIT] |=> o_pc_load && o_pc_value == PC_VECTOR)
    else $error("interrupt wake did not load the vector");

  chk_bor_flag_clear: assert property (
    rst_entry && i_brownout |=> !power_control_flags_q[POWER_CONTROL_FLAGS_BOR_BIT])
    else $error("brown-out flag not cleared");

  chk_wake_core_flag: assert property (
    irq_wake && i_wake_in_core |=> (irq_ctrl_q & $past(wake_mask)) != 8'h00)
    else $error("wake source flag not set");

  chk_gie_cleared: assert property (
    rst_src |=> !o_global_irq_enable)
    else $error("global enable survived reset");

  chk_strobe_release: assert property (
    !i_rst && o_reg_reset && !rst_src |=> !o_reg_reset ##0 state_q == ST_RUN)
    else $error("strobe not released with its source");
endmodule : reset_cause_and_init_control

/* File: logic/reset_ctl_pkg.sv */
// Constants for the reset cause and initialisation controller.
// Assumes a single 25 MHz clock; addresses are the core's 8-bit file addresses.
package reset_ctl_pkg;
  // Clock and master-clear filter timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MASTER_CLEAR_MIN_NS = 2000;
  localparam int unsigned MASTER_CLEAR_FILT_CYC = (MASTER_CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_W = 8;

  // Register file addresses
  localparam logic [7:0] ADDR_PCL = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0B;
  localparam logic [7:0] ADDR_PERIPH_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_POWER_CONTROL_FLAGS = 8'h8E;
  localparam logic [7:0] ADDR_KEEP = 8'h20;
  localparam logic [7:0] ADDR_CAUSE = 8'h21;
  localparam logic [7:0] ADDR_CAL = 8'h22;

  // Calibration word in program space
  localparam logic [13:0] CAL_WORD_ADDR = 14'h2008;

  // Field positions
  localparam int unsigned STATUS_TO_BIT = 4;
  localparam int unsigned STATUS_PD_BIT = 3;
  localparam int unsigned POWER_CONTROL_FLAGS_BOR_BIT = 0;
  localparam int unsigned POWER_CONTROL_FLAGS_POR_BIT = 1;
  localparam int unsigned GIE_BIT = 7;

  // Reset values and masks
  localparam logic [7:0] STATUS_POR_VAL = 8'h18;
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h07;
  localparam logic [7:0] POWER_CONTROL_FLAGS_POR_VAL = 8'h00;
  localparam logic [7:0] POWER_CONTROL_FLAGS_MASK = 8'h03;
  localparam logic [7:0] PERIPH_MASK = 8'h7B;
  localparam logic [7:0] REG_RST_VAL = 8'h00;
  localparam logic [7:0] PC_VECTOR = 8'h04;

  // Reset causes, one-hot
  typedef enum logic [5:0] {
    CAUSE_POR = 6'h01,
    CAUSE_WDT_RUN = 6'h02,
    CAUSE_WDT_SLEEP = 6'h04,
    CAUSE_MASTER_CLEAR_RUN = 6'h08,
    CAUSE_MASTER_CLEAR_SLEEP = 6'h10,
    CAUSE_BOR = 6'h20
  } cause_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_HOLD = 2'h2
  } state_t;
endpackage : reset_ctl_pkg

/* File: tb/reset_cause_and_init_control_test.sv */
// Self-checking bench for the reset cause and initialisation controller.
// Assumes the design's own assertions; drives all ports at the rising edge.
`timescale 1ns/1ps
module reset_cause_and_init_control_test;
  import reset_ctl_pkg::*;
  logic i_ref_clk = 1'h0;
  logic i_rst = 1'h1;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic i_master_clear_n = 1'h1;
  logic i_brownout = 1'h0;
  logic i_wdt_timeout = 1'h0;
  logic i_sleeping = 1'h0;
  logic i_wake_irq = 1'h0;
  logic i_wake_in_core = 1'h0;
  logic i_prog_wr = 1'h0;
  logic i_bulk_erase = 1'h0;
  logic [2:0] i_wake_bit = 3'h0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_next_pc = 8'h37;
  logic [7:0] i_prog_data = 8'h00;
  logic [13:0] i_prog_addr = 14'h0000;
  logic [7:0] o_rdata;
  logic [7:0] o_pc_value;
  logic [7:0] o_osc_trim;
  logic o_reg_reset;
  logic o_wake;
  logic o_pc_load;
  logic o_global_irq_enable;
  cause_t o_cause;
  int fails = 0;
  int checks = 0;

  always #20 i_ref_clk = ~i_ref_clk;

  reset_cause_and_init_control i_reset_cause_and_init_control (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_master_clear_n, .i_brownout, .i_wdt_timeout, .i_sleeping, .i_wake_irq, .i_wake_in_core,
    .i_wake_bit, .i_next_pc, .i_prog_wr, .i_prog_addr, .i_prog_data, .i_bulk_erase, .o_reg_reset, .o_wake,
    .o_pc_load, .o_pc_value, .o_global_irq_enable, .o_osc_trim, .o_cause);

  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : flag

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    #1;
    chk(what, exp, o_rdata);
  endtask : rd

  // Load values that a full reset must clear or keep
  task automatic prime;
    wr(ADDR_IRQ_CTRL, 8'h80);
    wr(ADDR_PERIPH_FLAGS, 8'h03);
    wr(ADDR_KEEP, 8'h5A);
    wr(ADDR_POWER_CONTROL_FLAGS, 8'h03);
  endtask : prime

  task automatic after_reset(input logic [7:0] st, input logic [7:0] power_control_flags);
    flag("gie", 1'h0, o_global_irq_enable);
    rd(ADDR_IRQ_CTRL, 8'h00, "irq ctrl");
    rd(ADDR_PERIPH_FLAGS, 8'h00, "periph");
    rd(ADDR_KEEP, 8'h5A, "keep");
    rd(ADDR_STATUS, st, "status");
    rd(ADDR_POWER_CONTROL_FLAGS, power_control_flags, "power_control_flags");
  endtask : after_reset

  // One-cycle brown-out (bo=1) or running watchdog (bo=0)
  task automatic src_pulse(input logic bo, input logic [5:0] cause);
    @(posedge i_ref_clk);
    i_brownout <= bo;
    i_wdt_timeout <= ~bo;
    @(posedge i_ref_clk);
    i_brownout <= 1'h0;
    i_wdt_timeout <= 1'h0;
    #1;
    flag("strobe", 1'h1, o_reg_reset);
    flag("pc load", 1'h1, o_pc_load);
    chk("pc", 8'h00, o_pc_value);
    chk("cause", {2'h0, cause}, {2'h0, o_cause});
    @(posedge i_ref_clk);
    #1;
    flag("strobe end", 1'h0, o_reg_reset);
  endtask : src_pulse

  task automatic master_clear(input int n, input logic slp, input int hit_exp);
    int k;
    int hit;
    hit = 0;
    @(posedge i_ref_clk);
    i_master_clear_n <= 1'h0;
    i_sleeping <= slp;
    for (k = 1; k <= n + 4; k++)
    begin
      @(posedge i_ref_clk);
      if (k == n)
      begin
        i_master_clear_n <= 1'h1;
        i_sleeping <= 1'h0;
      end
      #1;
      if (o_reg_reset === 1'h1 && hit == 0)
        hit = k;
    end
    chk("master_clear delay", 8'(hit_exp), 8'(hit));
    flag("master_clear end", 1'h0, o_reg_reset);
  endtask : master_clear

  // Wake from sleep by interrupt (irq=1) or watchdog (irq=0)
  task automatic wake(input logic irq, input logic core, input logic [2:0] b, input logic [7:0] pc);
    @(posedge i_ref_clk);
    i_sleeping <= 1'h1;
    i_wake_irq <= irq;
    i_wdt_timeout <= ~irq;
    i_wake_in_core <= core;
    i_wake_bit <= b;
    @(posedge i_ref_clk);
    i_sleeping <= 1'h0;
    i_wake_irq <= 1'h0;
    i_wdt_timeout <= 1'h0;
    #1;
    flag("wake", 1'h1, o_wake);
    flag("wake pc load", 1'h1, o_pc_load);
    flag("no strobe", 1'h0, o_reg_reset);
    chk("wake pc", pc, o_pc_value);
    @(posedge i_ref_clk);
    #1;
    flag("wake end", 1'h0, o_wake);
  endtask : wake

  task automatic calib;
    @(posedge i_ref_clk);
    i_prog_wr <= 1'h1;
    i_prog_addr <= CAL_WORD_ADDR;
    i_prog_data <= 8'h3C;
    @(posedge i_ref_clk);
    i_prog_addr <= 14'h2009;
    i_prog_data <= 8'h11;
    @(posedge i_ref_clk);
    i_prog_wr <= 1'h0;
    i_bulk_erase <= 1'h1;
    @(posedge i_ref_clk);
    i_bulk_erase <= 1'h0;
    @(posedge i_ref_clk);
    #1;
    chk("trim", 8'h3C, o_osc_trim);
    rd(ADDR_CAL, 8'h3C, "cal reg");
  endtask : calib

  initial
  begin
    #400000;
    fails++;
    complete_run;
  end

  // Power-on state at the first edge after reset release
  task automatic por_check;
    @(posedge i_ref_clk);
    #1;
    chk("por cause", 8'h01, {2'h0, o_cause});
    chk("por trim", 8'h80, o_osc_trim);
    flag("por strobe", 1'h0, o_reg_reset);
    flag("por pc load", 1'h0, o_pc_load);
    rd(ADDR_STATUS, 8'h18, "por status");
    rd(ADDR_POWER_CONTROL_FLAGS, 8'h00, "por power_control_flags");
    rd(8'h40, 8'h00, "unmapped");
  endtask : por_check

  // An interrupt while awake must neither wake nor load the program counter
  task automatic stray_wake;
    @(posedge i_ref_clk);
    i_wake_irq <= 1'h1;
    @(posedge i_ref_clk);
    i_wake_irq <= 1'h0;
    #1;
    flag("awake irq", 1'h0, o_wake);
    flag("awake pc load", 1'h0, o_pc_load);
  endtask : stray_wake

  // Software program counter write and cause register read-back
  task automatic soft_regs;
    wr(ADDR_PCL, 8'h2A);
    #1;
    flag("pcl load", 1'h1, o_pc_load);
    chk("pcl value", 8'h2A, o_pc_value);
    rd(ADDR_PCL, 8'h2A, "pcl read");
    rd(ADDR_CAUSE, 8'h10, "cause read");
  endtask : soft_regs

  initial
  begin
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    por_check;
    wr(ADDR_STATUS, 8'h05);
    prime;
    src_pulse(1'h1, 6'h20);
    after_reset(8'h1D, 8'h02);
    prime;
    src_pulse(1'h0, 6'h02);
    after_reset(8'h0D, 8'h03);
    master_clear(49, 1'h0, 0);
    prime;
    master_clear(60, 1'h0, 51);
    chk("master_clear cause", 8'h08, {2'h0, o_cause});
    after_reset(8'h0D, 8'h03);
    prime;
    wake(1'h0, 1'h0, 3'h0, 8'h37);
    chk("wdt wake cause", 8'h04, {2'h0, o_cause});
    rd(ADDR_IRQ_CTRL, 8'h80, "wdt wake irq");
    rd(ADDR_STATUS, 8'h05, "wdt wake status");
    wake(1'h1, 1'h1, 3'h1, 8'h04);
    rd(ADDR_IRQ_CTRL, 8'h82, "core flag");
    rd(ADDR_STATUS, 8'h15, "irq wake status");
    wr(ADDR_IRQ_CTRL, 8'h00);
    wake(1'h1, 1'h0, 3'h3, 8'h37);
    rd(ADDR_PERIPH_FLAGS, 8'h0B, "periph flag");
    stray_wake;
    prime;
    master_clear(60, 1'h1, 51);
    chk("sleep master_clear cause", 8'h10, {2'h0, o_cause});
    after_reset(8'h15, 8'h03);
    soft_regs;
    calib;
    complete_run;
  end
endmodule : reset_cause_and_init_control_test
